// >>> cie_consts.svh
// Purpose: Constant values for the instruction subset execution block.
// Assumes: Included by bare name; definitions only.
// Notes:   Status flag positions, opcode values, address limits and reset values.
`ifndef CIE_CONSTS_SVH
`define CIE_CONSTS_SVH

`define CIE_FLAG_C        0
`define CIE_FLAG_DC       1
`define CIE_FLAG_Z        2
`define CIE_FLAG_OV       3
`define CIE_FLAG_N        4

`define CIE_OPC_ADD_LIT   8'h0f
`define CIE_OPC_ADD_FILE  6'h09
`define CIE_OPC_DEC_FILE  6'h01
`define CIE_OPC_DEC_ADJ   16'h0007
`define CIE_OPC_BIT_SET   4'h8
`define CIE_OPC_FILL      7'h34

`define CIE_IDX_MAX       8'h5f
`define CIE_SFR_PAGE      4'hf
`define CIE_LOW_PAGE      4'h0

`define CIE_ACC_RST       8'h00
`define CIE_STATUS_RST    5'h00
`define CIE_BCD_MAX       5'h09
`define CIE_BCD_FIX       5'h06

`endif

// >>> cie_pkg.sv
// Purpose: Types shared by the instruction subset execution block.
// Assumes: Nothing is imported; users write cie_pkg::name.
// Notes:   State codes are Gray along the Q1 to Q4 path.
package cie_pkg;

    typedef enum logic [2:0] {
        op_add  = 3'h0,
        op_dec  = 3'h1,
        op_daw  = 3'h2,
        op_bset = 3'h3,
        op_fill = 3'h4,
        op_none = 3'h5
    } cie_op_t;

    typedef enum logic [2:0] {
        st_idle = 3'h0,
        st_q1   = 3'h1,
        st_q2   = 3'h3,
        st_q3   = 3'h2,
        st_q4   = 3'h6
    } cie_state_t;

endpackage

// >>> cie_alu_if.sv
// Purpose: Carrier between the sequencer and the arithmetic unit.
// Assumes: Purely combinational traffic within one clock cycle.
// Notes:   The mask marks which status flags the operation may change.
`timescale 1ns/1ps
`default_nettype none
interface cie_alu_if;
    cie_pkg::cie_op_t op;
    logic [7:0]       acc;
    logic [7:0]       operand;
    logic [2:0]       bit_sel;
    logic             c_in;
    logic             dc_in;
    logic [7:0]       result;
    logic [4:0]       flags;
    logic [4:0]       mask;

    modport seq (output op, acc, operand, bit_sel, c_in, dc_in, input result, flags, mask);
    modport alu (input op, acc, operand, bit_sel, c_in, dc_in, output result, flags, mask);
endinterface
`default_nettype wire

// >>> cie_alu.sv
// Purpose: Arithmetic for add, decrement, decimal adjust, bit set and fill.
// Assumes: Inputs are stable for the whole cycle in which they are sampled.
// Notes:   Decrement adds all ones, so carry reads as not-borrow.
`include "cie_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module cie_alu (
    cie_alu_if.alu bus
);
    logic [8:0] sum9;
    logic [4:0] lo5;
    logic [4:0] hi5;
    logic [4:0] hi_base;
    logic [7:0] res;
    logic       c;
    logic       dc;
    logic       ov;
    logic [4:0] mask;

    always_comb begin
        sum9    = 9'h000;
        lo5     = 5'h00;
        hi5     = 5'h00;
        hi_base = 5'h00;
        res     = 8'h00;
        c       = bus.c_in;
        dc      = bus.dc_in;
        ov      = 1'b0;
        mask    = 5'h00;
        case (bus.op)
            cie_pkg::op_add: begin
                sum9 = {1'b0, bus.acc} + {1'b0, bus.operand};
                lo5  = {1'b0, bus.acc[3:0]} + {1'b0, bus.operand[3:0]};
                res  = sum9[7:0];
                c    = sum9[8];
                dc   = lo5[4];
                ov   = (bus.acc[7] == bus.operand[7]) && (res[7] != bus.acc[7]);
                mask = 5'h1f;
            end
            cie_pkg::op_dec: begin
                sum9 = {1'b0, bus.operand} + 9'h0ff;
                lo5  = {1'b0, bus.operand[3:0]} + 5'h0f;
                res  = sum9[7:0];
                c    = sum9[8];
                dc   = lo5[4];
                ov   = bus.operand[7] & ~res[7];
                mask = 5'h1f;
            end
            cie_pkg::op_daw: begin
                if ((({1'b0, bus.acc[3:0]}) > `CIE_BCD_MAX) || bus.dc_in) begin
                    lo5 = {1'b0, bus.acc[3:0]} + `CIE_BCD_FIX;
                end else begin
                    lo5 = {1'b0, bus.acc[3:0]};
                end
                // The low-digit correction carry is the digit carry fed upward.
                hi_base = {1'b0, bus.acc[7:4]} + {4'h0, lo5[4]};
                if ((hi_base > `CIE_BCD_MAX) || bus.c_in) begin
                    hi5 = hi_base + `CIE_BCD_FIX;
                end else begin
                    hi5 = hi_base;
                end
                res  = {hi5[3:0], lo5[3:0]};
                c    = bus.c_in | hi5[4] | hi_base[4];
                mask = 5'h01 << `CIE_FLAG_C;
            end
            cie_pkg::op_bset: begin
                res  = bus.operand | (8'h01 << bus.bit_sel);
            end
            cie_pkg::op_fill: begin
                res  = 8'hff;
            end
            default: begin
                res  = bus.operand;
            end
        endcase
    end

    always_comb begin
        bus.result               = res;
        bus.mask                 = mask;
        bus.flags                = 5'h00;
        bus.flags[`CIE_FLAG_C]   = c;
        bus.flags[`CIE_FLAG_DC]  = dc;
        bus.flags[`CIE_FLAG_Z]   = (res == 8'h00);
        bus.flags[`CIE_FLAG_OV]  = ov;
        bus.flags[`CIE_FLAG_N]   = res[7];
    end
endmodule
`default_nettype wire

// >>> cie_exec.sv
// Purpose: Decode and execute a subset of an 8-bit core's instructions.
// Assumes: Data memory answers a read one cycle after o_mem_rd.
// Notes:   Each instruction walks Q1 decode, Q2 read, Q3 process, Q4 write.
//          Two-word instructions are not handled; only their first word is decoded.
// Operation
// - Opcode 001001da adds accumulator to file register at 8-bit address.
// - Opcode 000001da decrements file register, updating C, DC, N, OV, Z.
// - Destination bit 0 writes accumulator; 1 writes back to the file.
// - Access bit 0 selects access bank; 1 uses bank select register.
// - Access bit 0, extended set on, address at most 95: indexed offset.
// - Indexed add sums accumulator and byte at pointer two plus k.
// - Indexed bit set sets bit b of byte at pointer two plus k.
// - Indexed fill writes all ones at pointer two plus k, flags kept.
// - Upper nibble gets the low-digit carry, plus six when above nine or carry set.
// - Decimal adjust fixes packed BCD in accumulator, changing only carry.
`include "cie_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module cie_exec (
    input  wire logic        i_core_clk,
    input  wire logic        i_reset,
    input  wire logic        i_instr_valid,
    input  wire logic [15:0] i_instr,
    input  wire logic        i_ext_set_en,
    input  wire logic [3:0]  i_bank_select_reg,
    input  wire logic [11:0] i_pointer_reg_two,
    input  wire logic [7:0]  i_mem_rdata,
    output logic             o_instr_ready,
    output logic [11:0]      o_mem_addr,
    output logic             o_mem_rd,
    output logic             o_mem_we,
    output logic [7:0]       o_mem_wdata,
    output logic [7:0]       o_acc,
    output logic [4:0]       o_status,
    output logic             o_unsupported,
    output logic             o_retire
);
    // Indexed form applies only to access-bank operands in the low window.
    function automatic logic is_indexed(input logic [7:0] f, input logic a, input logic ext);
        is_indexed = ~a & ext & (f <= `CIE_IDX_MAX);
    endfunction

    // The indexed sum wraps at twelve bits, as the pointer register itself does.
    function automatic logic [11:0] file_addr(input logic [7:0] f, input logic a,
                                              input logic ext, input logic [3:0] bank_select_reg,
                                              input logic [11:0] ptr);
        if (is_indexed(f, a, ext)) begin
            file_addr = ptr + {4'h0, f};
        end else if (a) begin
            file_addr = {bank_select_reg, f};
        end else if (f <= `CIE_IDX_MAX) begin
            file_addr = {`CIE_LOW_PAGE, f};
        end else begin
            file_addr = {`CIE_SFR_PAGE, f};
        end
    endfunction

    cie_pkg::cie_state_t state_q, state_d;
    cie_pkg::cie_op_t    op_q, op_d;
    logic [15:0] instr_q, instr_d;
    logic [11:0] addr_q, addr_d;
    logic        to_file_q, to_file_d;
    logic        rd_q, rd_d;
    logic [7:0]  result_q, result_d;
    logic [4:0]  flags_q, flags_d;
    logic [4:0]  mask_q, mask_d;
    logic [7:0]  acc_q, acc_d;
    logic [4:0]  status_q, status_d;
    logic        take;

    cie_alu_if alu_bus ();

    cie_alu u_alu (
        .bus (alu_bus)
    );

    // Ready in Q4 lets the next word be taken while this one writes back, so
    // instructions run back to back with no idle cycle between them.
    assign o_instr_ready = (state_q == cie_pkg::st_idle) || (state_q == cie_pkg::st_q4);
    assign take          = o_instr_ready & i_instr_valid;
    assign o_mem_rd      = (state_q == cie_pkg::st_q2) & rd_q;
    assign o_mem_we      = (state_q == cie_pkg::st_q4) & to_file_q & (op_q != cie_pkg::op_none);
    assign o_unsupported = (state_q == cie_pkg::st_q4) & (op_q == cie_pkg::op_none);
    assign o_retire      = (state_q == cie_pkg::st_q4);
    assign o_mem_addr    = addr_q;
    assign o_mem_wdata   = result_q;
    assign o_acc         = acc_q;
    assign o_status      = status_q;

    always_comb begin
        alu_bus.op      = op_q;
        alu_bus.acc     = acc_q;
        alu_bus.operand = rd_q ? i_mem_rdata : instr_q[7:0];
        alu_bus.bit_sel = instr_q[11:9];
        alu_bus.c_in    = status_q[`CIE_FLAG_C];
        alu_bus.dc_in   = status_q[`CIE_FLAG_DC];
    end

    always_comb begin
        state_d   = state_q;
        op_d      = op_q;
        instr_d   = instr_q;
        addr_d    = addr_q;
        to_file_d = to_file_q;
        rd_d      = rd_q;
        result_d  = result_q;
        flags_d   = flags_q;
        mask_d    = mask_q;
        case (state_q)
            cie_pkg::st_idle: begin
                if (take) begin
                    instr_d = i_instr;
                    state_d = cie_pkg::st_q1;
                end
            end
            cie_pkg::st_q1: begin
                // The address is sampled at decode so later pointer changes cannot skew it.
                addr_d    = file_addr(instr_q[7:0], instr_q[8], i_ext_set_en,
                                      i_bank_select_reg, i_pointer_reg_two);
                op_d      = cie_pkg::op_none;
                to_file_d = 1'b0;
                rd_d      = 1'b0;
                // The patterns do not overlap; a word that matches none walks all four
                // phases as a no-op, so the fetch rhythm never changes.
                if (instr_q[15:8] == `CIE_OPC_ADD_LIT) begin
                    op_d = cie_pkg::op_add;
                end else if (instr_q == `CIE_OPC_DEC_ADJ) begin
                    op_d = cie_pkg::op_daw;
                end else if (instr_q[15:10] == `CIE_OPC_ADD_FILE) begin
                    op_d      = cie_pkg::op_add;
                    rd_d      = 1'b1;
                    to_file_d = instr_q[9];
                end else if (instr_q[15:10] == `CIE_OPC_DEC_FILE) begin
                    op_d      = cie_pkg::op_dec;
                    rd_d      = 1'b1;
                    to_file_d = instr_q[9];
                end else if (instr_q[15:12] == `CIE_OPC_BIT_SET) begin
                    op_d      = cie_pkg::op_bset;
                    rd_d      = 1'b1;
                    to_file_d = 1'b1;
                end else if (instr_q[15:9] == `CIE_OPC_FILL) begin
                    op_d      = cie_pkg::op_fill;
                    to_file_d = 1'b1;
                end
                state_d = cie_pkg::st_q2;
            end
            cie_pkg::st_q2: begin
                state_d = cie_pkg::st_q3;
            end
            cie_pkg::st_q3: begin
                // Captured here so that Q4 drives memory from flip-flops, not the ALU.
                result_d = alu_bus.result;
                flags_d  = alu_bus.flags;
                mask_d   = alu_bus.mask;
                state_d  = cie_pkg::st_q4;
            end
            cie_pkg::st_q4: begin
                if (take) begin
                    instr_d = i_instr;
                    state_d = cie_pkg::st_q1;
                end else begin
                    state_d = cie_pkg::st_idle;
                end
            end
            default: begin
                state_d = cie_pkg::st_idle;
            end
        endcase
    end

    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            state_q   <= cie_pkg::st_idle;
            op_q      <= cie_pkg::op_none;
            instr_q   <= 16'h0000;
            addr_q    <= 12'h000;
            to_file_q <= 1'b0;
            rd_q      <= 1'b0;
            result_q  <= 8'h00;
            flags_q   <= 5'h00;
            mask_q    <= 5'h00;
        end else begin
            state_q   <= state_d;
            op_q      <= op_d;
            instr_q   <= instr_d;
            addr_q    <= addr_d;
            to_file_q <= to_file_d;
            rd_q      <= rd_d;
            result_q  <= result_d;
            flags_q   <= flags_d;
            mask_q    <= mask_d;
        end
    end

    // Accumulator and flags are the program-visible state and form their own group.
    // They commit at the end of Q4 only, so a word taken in that same Q4 already
    // sees them updated when it reaches its own Q3.
    always_comb begin
        acc_d    = acc_q;
        status_d = status_q;
        if ((state_q == cie_pkg::st_q4) && (op_q != cie_pkg::op_none)) begin
            if (!to_file_q) begin
                acc_d = result_q;
            end
            // Only flags named by the mask move; bit set and fill keep all.
            status_d = (status_q & ~mask_q) | (flags_q & mask_q);
        end
    end

    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            acc_q    <= `CIE_ACC_RST;
            status_q <= `CIE_STATUS_RST;
        end else begin
            acc_q    <= acc_d;
            status_q <= status_d;
        end
    end
endmodule
`default_nettype wire

// >>> cie_exec_props.sv
// Purpose: Port-level checks for the instruction subset execution block.
// Assumes: Bank select and pointer inputs stay steady while an instruction runs.
// Notes:   Delays count from the edge that takes the instruction.
`timescale 1ns/1ps
`default_nettype none
module cie_exec_props (
    input wire logic        i_core_clk,
    input wire logic        i_reset,
    input wire logic        i_instr_valid,
    input wire logic [15:0] i_instr,
    input wire logic        i_ext_set_en,
    input wire logic [3:0]  i_bank_select_reg,
    input wire logic [11:0] i_pointer_reg_two,
    input wire logic        o_instr_ready,
    input wire logic [11:0] o_mem_addr,
    input wire logic        o_mem_rd,
    input wire logic        o_mem_we,
    input wire logic [7:0]  o_mem_wdata,
    input wire logic [4:0]  o_status,
    input wire logic        o_retire
);
    wire logic idx_op = !i_instr[8] && i_ext_set_en && (i_instr[7:0] <= 8'h5f) &&
        (i_instr[15:12] == 4'h8 || i_instr[15:9] == 7'h34 || i_instr[15:10] == 6'h09);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_reset);
    sequence s_take(cond);
        i_instr_valid && o_instr_ready && cond;
    endsequence
    sequence s_walk;
        !o_instr_ready [*3] ##1 (o_instr_ready && o_retire);
    endsequence
    a_walk_length: assert property (s_take(1'b1) |=> s_walk)
        else $error("Instruction walk has the wrong length.");
    a_add_read: assert property (s_take(i_instr[15:10] == 6'h09) |-> ##2 o_mem_rd)
        else $error("File add did not read memory in Q2.");
    a_dest_file: assert property (s_take(i_instr[15:9] == 7'h13) |-> ##4 o_mem_we)
        else $error("File destination was not written.");
    a_dest_acc: assert property (s_take(i_instr[15:9] == 7'h12) |-> ##4 !o_mem_we)
        else $error("Accumulator destination wrote memory.");
    a_bank_addr: assert property (s_take(i_instr[15:10] == 6'h09 && i_instr[8])
        |-> ##2 o_mem_addr == {i_bank_select_reg, $past(i_instr[7:0], 2)})
        else $error("Banked address is wrong.");
    a_index_addr: assert property (s_take(idx_op)
        |-> ##2 o_mem_addr == i_pointer_reg_two + {4'h0, $past(i_instr[7:0], 2)})
        else $error("Indexed address is wrong.");
    a_fill_ones: assert property (s_take(i_instr[15:9] == 7'h34)
        |-> ##4 o_mem_we && o_mem_wdata == 8'hff)
        else $error("Fill did not write all ones.");
    a_bit_set: assert property (s_take(i_instr[15:12] == 4'h8)
        |-> ##4 o_mem_we && ((o_mem_wdata >> $past(i_instr[11:9], 4)) & 8'h01) == 8'h01)
        else $error("Selected bit was not set.");
    a_flags_kept: assert property (s_take(i_instr[15:12] == 4'h8 ||
        i_instr[15:9] == 7'h34) |-> ##5 $stable(o_status))
        else $error("Bit set or fill changed the flags.");
    a_adjust_only_c: assert property (s_take(i_instr == 16'h0007)
        |-> ##5 $stable(o_status[4:1]))
        else $error("Decimal adjust changed a flag other than carry.");
    a_lit_no_mem: assert property (s_take(i_instr[15:8] == 8'h0f)
        |-> ##1 (!o_mem_rd && !o_mem_we) [*4])
        else $error("Literal add touched memory.");
endmodule
bind cie_exec cie_exec_props i_cie_exec_props (.i_core_clk(i_core_clk), .i_reset(i_reset),
    .i_instr_valid(i_instr_valid), .i_instr(i_instr), .i_ext_set_en(i_ext_set_en),
    .i_bank_select_reg(i_bank_select_reg), .i_pointer_reg_two(i_pointer_reg_two),
    .o_instr_ready(o_instr_ready), .o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd),
    .o_mem_we(o_mem_we), .o_mem_wdata(o_mem_wdata), .o_status(o_status), .o_retire(o_retire));
`default_nettype wire

// >>> cie_mem_model.sv
// Purpose: Behavioural data memory facing the execution block.
// Assumes: One cycle read latency, write on the Q4 strobe.
// Notes:   Read data toggles when no read is pending, so a stale sample shows up.
`timescale 1ns/1ps
`default_nettype none
module cie_mem_model (
    input  wire logic        i_core_clk,
    input  wire logic [11:0] i_mem_addr,
    input  wire logic        i_mem_rd,
    input  wire logic        i_mem_we,
    input  wire logic [7:0]  i_mem_wdata,
    output logic      [7:0]  o_mem_rdata
);
    logic [7:0] mem [4096];
    initial o_mem_rdata = 8'h00;
    always @(posedge i_core_clk) begin
        if (i_mem_we) mem[i_mem_addr] <= i_mem_wdata;
        if (i_mem_rd) o_mem_rdata <= mem[i_mem_addr];
        else o_mem_rdata <= ~o_mem_rdata;
    end
endmodule
`default_nettype wire

// >>> cie_exec_bench.sv
// Purpose: Self-checking bench for the instruction subset execution block.
// Assumes: Memory contents are preset straight into the memory model.
// Notes:   Each instruction is run alone except one back-to-back pair; results are read after Q4.
`timescale 1ns/1ps
`default_nettype none
module cie_exec_bench;
    logic        i_core_clk = 1'b0;
    logic        i_reset;
    logic        i_instr_valid;
    logic [15:0] i_instr;
    logic        i_ext_set_en;
    logic [3:0]  i_bank_select_reg;
    logic [11:0] i_pointer_reg_two;
    logic [7:0]  mem_rdata;
    logic [11:0] mem_addr;
    logic        mem_rd;
    logic        mem_we;
    logic [7:0]  mem_wdata;
    logic [7:0]  o_acc;
    logic [4:0]  o_status;
    logic        o_unsupported;
    logic        o_retire;
    logic        unsup;
    logic        instr_ready;
    int          error_cnt = 0;
    int          total_checks = 0;
    logic [7:0]  daw_a [4] = '{8'h00, 8'h00, 8'h09, 8'h99};
    logic [7:0]  daw_b [4] = '{8'ha5, 8'hce, 8'h08, 8'h99};
    logic [7:0]  daw_acc [4] = '{8'h05, 8'h34, 8'h17, 8'h98};
    logic [4:0]  daw_st [4] = '{5'h11, 5'h11, 5'h02, 5'h0b};
    always #5 i_core_clk = ~i_core_clk;
    cie_exec i_cie_exec (.i_core_clk(i_core_clk), .i_reset(i_reset),
        .i_instr_valid(i_instr_valid), .i_instr(i_instr), .i_ext_set_en(i_ext_set_en),
        .i_bank_select_reg(i_bank_select_reg), .i_pointer_reg_two(i_pointer_reg_two),
        .i_mem_rdata(mem_rdata), .o_instr_ready(instr_ready), .o_mem_addr(mem_addr),
        .o_mem_rd(mem_rd), .o_mem_we(mem_we), .o_mem_wdata(mem_wdata), .o_acc(o_acc),
        .o_status(o_status), .o_unsupported(o_unsupported), .o_retire(o_retire));
    cie_mem_model i_cie_mem_model (.i_core_clk(i_core_clk), .i_mem_addr(mem_addr),
        .i_mem_rd(mem_rd), .i_mem_we(mem_we), .i_mem_wdata(mem_wdata), .o_mem_rdata(mem_rdata));
    task automatic give_verdict;
        if (error_cnt == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_flags(input logic [4:0] exp);
        total_checks++;
        if (o_status !== exp) begin
            error_cnt++;
            $display("MISMATCH status expected %h seen %h", exp, o_status);
        end
    endtask
    // Holds the word until the edge at which ready stands high; valid stays up when
    // another word follows straight away.
    task automatic offer(input logic [15:0] ins, input logic last);
        int n;
        n = 0;
        i_instr_valid <= 1'b1;
        i_instr       <= ins;
        @(negedge i_core_clk);
        while (instr_ready !== 1'b1 && n < 8) begin
            @(negedge i_core_clk);
            n++;
        end
        if (n >= 8) begin
            error_cnt++;
            give_verdict();
        end
        @(posedge i_core_clk);
        if (last) begin
            i_instr_valid <= 1'b0;
        end
    endtask
    // Offers one word, waits for Q4 and returns once the registered results settle.
    task automatic run(input logic [15:0] ins);
        @(posedge i_core_clk);
        offer(ins, 1'b1);
        await_retire();
    endtask
    task automatic await_retire;
        int n;
        n = 0;
        do begin
            @(negedge i_core_clk);
            n++;
        end while (o_retire !== 1'b1 && n < 8);
        if (n >= 8) begin
            error_cnt++;
            give_verdict();
        end
        unsup = o_unsupported;
        @(posedge i_core_clk);
        @(negedge i_core_clk);
    endtask
    task automatic pulse_reset;
        @(posedge i_core_clk);
        i_reset <= 1'b1;
        @(posedge i_core_clk);
        i_reset <= 1'b0;
    endtask
    initial begin
        i_reset <= 1'b1;
        i_instr_valid <= 1'b0;
        i_instr <= 16'h0000;
        i_ext_set_en <= 1'b0;
        i_bank_select_reg <= 4'h3;
        i_pointer_reg_two <= 12'ha00;
        i_cie_mem_model.mem[12'h340] = 8'hc2;
        i_cie_mem_model.mem[12'h341] = 8'h01;
        i_cie_mem_model.mem[12'hf80] = 8'h01;
        i_cie_mem_model.mem[12'h020] = 8'h80;
        i_cie_mem_model.mem[12'ha2c] = 8'h20;
        i_cie_mem_model.mem[12'ha0a] = 8'h55;
        i_cie_mem_model.mem[12'ha10] = 8'h00;
        repeat (12) @(posedge i_core_clk);
        i_reset <= 1'b0;
        run(16'h0f17);
        chk_byte("acc", 8'h17, o_acc);
        chk_flags(5'h00);
        run(16'h2540);
        chk_byte("acc", 8'hd9, o_acc);
        chk_flags(5'h10);
        run(16'h2741);
        chk_byte("mem341", 8'hda, i_cie_mem_model.mem[12'h341]);
        chk_byte("acc", 8'hd9, o_acc);
        run(16'h0680);
        chk_byte("memf80", 8'h00, i_cie_mem_model.mem[12'hf80]);
        chk_flags(5'h07);
        run(16'h0420);
        chk_byte("acc", 8'h7f, o_acc);
        chk_flags(5'h09);
        @(posedge i_core_clk);
        i_ext_set_en <= 1'b1;
        run(16'h0f98);
        chk_flags(5'h03);
        run(16'h242c);
        chk_byte("acc", 8'h37, o_acc);
        chk_byte("mema2c", 8'h20, i_cie_mem_model.mem[12'ha2c]);
        run(16'h0fc9);
        chk_flags(5'h07);
        run(16'h8e0a);
        chk_byte("mema0a", 8'hd5, i_cie_mem_model.mem[12'ha0a]);
        for (int b = 0; b < 8; b++) begin
            run({4'h8, b[2:0], 1'b0, 8'h10});
            chk_byte("mema10", 8'((32'h1 << (b + 1)) - 1), i_cie_mem_model.mem[12'ha10]);
        end
        chk_flags(5'h07);
        run(16'h682c);
        chk_byte("mema2c", 8'hff, i_cie_mem_model.mem[12'ha2c]);
        run(16'h685f);
        chk_byte("mema5f", 8'hff, i_cie_mem_model.mem[12'ha5f]);
        run(16'h6860);
        chk_byte("memf60", 8'hff, i_cie_mem_model.mem[12'hf60]);
        chk_flags(5'h07);
        run(16'hf000);
        chk_byte("unsupported", 8'h01, {7'h00, unsup});
        chk_byte("acc", 8'h00, o_acc);
        // Second word is taken in the first word's Q4, with no idle cycle.
        @(posedge i_core_clk);
        offer(16'h0f11, 1'b0);
        offer(16'h0f22, 1'b1);
        await_retire();
        chk_byte("acc", 8'h33, o_acc);
        chk_flags(5'h00);
        chk_byte("unsupported", 8'h00, {7'h00, unsup});
        for (int t = 0; t < 4; t++) begin
            pulse_reset();
            run({8'h0f, daw_a[t]});
            run({8'h0f, daw_b[t]});
            run(16'h0007);
            chk_byte("acc", daw_acc[t], o_acc);
            chk_flags(daw_st[t]);
        end
        give_verdict();
    end
endmodule
`default_nettype wire
